// ### cca_array.v
// counter array: shared 16-bit counter, three capture/compare modules, registers
// assumes an 8-bit register port with one-cycle write strobe and combinational read
// What this block does
// - rise select bit 5, fall select bit 4, both select any edge.
// - capture copies counter into compare register and sets event flag.
// - event flag stays set until software writes it clear.
// - mode bit 0 lets the event flag raise an interrupt request.
// - comparator and match enables give timer mode; 16-bit match sets flag.
// - low byte write clears comparator enable, high byte write sets it.
// - toggle mode inverts pin and sets flag on each 16-bit match.
// - toggle mode with comparator off holds pin_o level and releases the pin (pin_oe_n_o high).
// - frequency mode toggles on low byte match, adds high byte.
// - frequency half-period zero counts as 256.
// - frequency mode with match enable flags full 16-bit match.
// - 8-bit PWM sets pin on low byte match, clears on overflow.
// - 8-bit PWM reloads low byte from high byte on wrap.
// - cycle length field selects 8, 9, 10 or 11 bit PWM, shared.
// - cycle overflow flag set on every bit-N overflow.
// - overflow interrupt enable gates the cycle overflow flag.
// - bank select bit 7 routes compare addresses to reload registers.
// - wide PWM sets pin on low N bit match, clears on overflow.
// - wide PWM copies reload into compare on bit-N overflow.
// - PWM match with match enable sets event flag.
// - PWM with comparator off holds output low.
// - 16-bit PWM sets on full match, clears on counter overflow.
`timescale 1ns/1ps
`include "cca_regs.vh"
module cca_array (
  input  wire        core_clk_i,    // system clock, 25 MHz
  input  wire        reset_i,       // async reset, active high
  input  wire        cnt_tick_i,    // timebase advance strobe, same domain
  input  wire        cnt_run_i,     // counter run enable
  input  wire [3:0]  reg_addr_i,    // register address
  input  wire        reg_wr_i,      // register write strobe
  input  wire        reg_rd_i,      // register read strobe
  input  wire [7:0]  reg_wdata_i,   // write data
  output reg  [7:0]  reg_rdata_o,   // read data
  input  wire [2:0]  pin_i,         // module_io_pin input levels
  output wire [2:0]  pin_o,         // module_io_pin drive levels
  output wire [2:0]  pin_oe_n_o,    // pin output enable, low while driving
  output wire        irq_o          // combined interrupt request
);
  reg  [15:0] count_r;
  reg  [7:0]  snap_r;
  reg  [7:0]  mode_r [0:2];
  reg  [2:0]  flag_r;
  reg  [7:0]  pwmc_r;
  wire [2:0]  rise;
  wire [2:0]  fall;
  wire [2:0]  evt;
  wire [15:0] cmp [0:2];
  wire [15:0] rld [0:2];
  wire [2:0]  wr_lo;
  wire [2:0]  wr_hi;
  wire [1:0]  cycle_length_select = pwmc_r[`CCA_PC_CYCLE_LENGTH_SELECT_HI:`CCA_PC_CYCLE_LENGTH_SELECT_LO];
  wire        bank  = pwmc_r[`CCA_PC_BANK_SEL];
  wire        tick  = cnt_tick_i & cnt_run_i;
  wire        ovf_n = tick & ((count_r[10:0] | ~{cycle_length_select == 2'b11, cycle_length_select[1], |cycle_length_select, 8'hFF})
                      == 11'h7FF);

  function is_mod_addr;
    input [3:0] a;
    input [3:0] base;
    input integer i;
    begin
      is_mod_addr = (a == base + i[3:0]);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : mods
      assign wr_lo[g] = reg_wr_i & is_mod_addr(reg_addr_i, `CCA_ADDR_CMPL_BASE, g);
      assign wr_hi[g] = reg_wr_i & is_mod_addr(reg_addr_i, `CCA_ADDR_CMPH_BASE, g);
      cca_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (pin_i[g]),
        .level_o    (),
        .rise_o     (rise[g]),
        .fall_o     (fall[g])
      );
      cca_module u_mod (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .mode_i     (mode_r[g]),
        .count_i    (count_r),
        .tick_i     (tick),
        .cycle_length_select_i    (cycle_length_select),
        .ovf_n_i    (ovf_n),
        .bank_i     (bank),
        .wr_low_i   (wr_lo[g]),
        .wr_high_i  (wr_hi[g]),
        .wdata_i    (reg_wdata_i),
        .pin_rise_i (rise[g]),
        .pin_fall_i (fall[g]),
        .cmp_o      (cmp[g]),
        .reload_o   (rld[g]),
        .pin_o      (pin_o[g]),
        .event_o    (evt[g])
      );
      // capture modes leave the pin undriven
      assign pin_oe_n_o[g] = ~(mode_r[g][`CCA_MD_CMP_EN] | mode_r[g][`CCA_MD_PWM_EN]);
    end
  endgenerate

  integer k;
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_r <= 16'h0000;
      snap_r  <= 8'h00;
      flag_r  <= 3'h0;
      pwmc_r  <= `CCA_PWMC_RESET;
      for (k = 0; k < 3; k = k + 1)
        mode_r[k] <= `CCA_MODE_RESET;
    end
    else
    begin
      if (reg_wr_i & (reg_addr_i == `CCA_ADDR_CNT_LOW))
        count_r[7:0] <= reg_wdata_i;
      else if (reg_wr_i & (reg_addr_i == `CCA_ADDR_CNT_HIGH))
        count_r[15:8] <= reg_wdata_i;
      else if (tick)
        count_r <= count_r + 16'h0001;
      // low byte read latches high byte for a coherent 16-bit read
      if (reg_rd_i & (reg_addr_i == `CCA_ADDR_CNT_LOW))
        snap_r <= count_r[15:8];
      if (reg_wr_i & (reg_addr_i == `CCA_ADDR_ARRAY_CTRL))
        flag_r <= (flag_r & reg_wdata_i[2:0]) | evt;
      else
        flag_r <= flag_r | evt;
      if (reg_wr_i & (reg_addr_i == `CCA_ADDR_PWM_CTRL))
        pwmc_r <= {reg_wdata_i[7:6], reg_wdata_i[5] & pwmc_r[5] | ovf_n,
                   3'h0, reg_wdata_i[1:0]};
      else if (ovf_n)
        pwmc_r[`CCA_PC_OVF_FLAG] <= 1'b1;
      for (k = 0; k < 3; k = k + 1)
      begin
        if (reg_wr_i & (reg_addr_i == `CCA_ADDR_MODE_BASE + k[3:0]))
          mode_r[k] <= reg_wdata_i;
        else if (wr_lo[k])
          mode_r[k][`CCA_MD_CMP_EN] <= 1'b0;
        else if (wr_hi[k])
          mode_r[k][`CCA_MD_CMP_EN] <= 1'b1;
      end
    end
  end

  assign irq_o = |(flag_r & {mode_r[2][0], mode_r[1][0], mode_r[0][0]}) |
                 (pwmc_r[`CCA_PC_OVF_FLAG] & pwmc_r[`CCA_PC_OVF_IRQ_EN]);

  always @*
  begin
    reg_rdata_o = 8'h00;
    case (reg_addr_i)
      `CCA_ADDR_ARRAY_CTRL: reg_rdata_o = {5'h00, flag_r};
      `CCA_ADDR_PWM_CTRL:   reg_rdata_o = pwmc_r;
      `CCA_ADDR_CNT_LOW:    reg_rdata_o = count_r[7:0];
      `CCA_ADDR_CNT_HIGH:   reg_rdata_o = snap_r;
      4'h4, 4'h5, 4'h6:     reg_rdata_o = mode_r[reg_addr_i[1:0]];
      4'h8, 4'h9, 4'hA:     reg_rdata_o = bank ? rld[reg_addr_i[1:0]][7:0] :
                                                 cmp[reg_addr_i[1:0]][7:0];
      4'hC, 4'hD, 4'hE:     reg_rdata_o = bank ? rld[reg_addr_i[1:0]][15:8] :
                                                 cmp[reg_addr_i[1:0]][15:8];
      default:              reg_rdata_o = 8'h00;
    endcase
  end
endmodule

// ### cca_regs.vh
// constants for the counter array capture/compare block
// assumes an 8-bit special function register port with a small local address space
`ifndef CCA_REGS_VH
`define CCA_REGS_VH
`define CCA_NUM_MODULES      3
// register addresses on the local 8-bit register port
`define CCA_ADDR_ARRAY_CTRL  4'h0
`define CCA_ADDR_PWM_CTRL    4'h1
`define CCA_ADDR_CNT_LOW     4'h2
`define CCA_ADDR_CNT_HIGH    4'h3
`define CCA_ADDR_MODE_BASE   4'h4
`define CCA_ADDR_CMPL_BASE   4'h8
`define CCA_ADDR_CMPH_BASE   4'hC
// module_mode_control fields
`define CCA_MD_WIDE_PWM      7
`define CCA_MD_CMP_EN        6
`define CCA_MD_CAP_RISE      5
`define CCA_MD_CAP_FALL      4
`define CCA_MD_MATCH_EN      3
`define CCA_MD_TOGGLE_EN     2
`define CCA_MD_PWM_EN        1
`define CCA_MD_IRQ_EN        0
// pwm_cycle_control fields
`define CCA_PC_BANK_SEL      7
`define CCA_PC_OVF_FLAG      5
`define CCA_PC_OVF_IRQ_EN    6
`define CCA_PC_CYCLE_LENGTH_SELECT_HI      1
`define CCA_PC_CYCLE_LENGTH_SELECT_LO      0
`define CCA_MODE_RESET       8'h00
`define CCA_PWMC_RESET       8'h00
`define CCA_CMP_RESET        16'h0000
`endif

// ### cca_pin_sync.v
// two-stage synchroniser with edge outputs for one module pin
// assumes the pin is asynchronous to core_clk_i
`timescale 1ns/1ps
`include "cca_regs.vh"
module cca_pin_sync (
  input  wire core_clk_i,  // system clock
  input  wire reset_i,     // async reset, active high
  input  wire pin_i,       // raw pin level
  output wire level_o,     // synchronised level
  output wire rise_o,      // one-cycle rising pulse
  output wire fall_o       // one-cycle falling pulse
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;
endmodule

// ### cca_module.v
// one capture/compare module: compare register, reload register, pin logic
// assumes the shared counter and its advance strobe come from the array top
`timescale 1ns/1ps
`include "cca_regs.vh"
module cca_module (
  input  wire        core_clk_i,   // system clock
  input  wire        reset_i,      // async reset, active high
  input  wire [7:0]  mode_i,       // module_mode_control
  input  wire [15:0] count_i,      // shared counter value
  input  wire        tick_i,       // counter advances this cycle
  input  wire [1:0]  cycle_length_select_i,      // cycle_length_select
  input  wire        ovf_n_i,      // bit-N overflow on this tick
  input  wire        bank_i,       // reload_bank_select
  input  wire        wr_low_i,     // write compare_low_byte
  input  wire        wr_high_i,    // write compare_high_byte
  input  wire [7:0]  wdata_i,      // write data
  input  wire        pin_rise_i,   // synchronised rising edge
  input  wire        pin_fall_i,   // synchronised falling edge
  output reg  [15:0] cmp_o,        // compare_value
  output reg  [15:0] reload_o,     // auto-reload register
  output reg         pin_o,        // module_io_pin drive level
  output wire        event_o       // sets module_event_flag
);
  wire cmp_en = mode_i[`CCA_MD_CMP_EN];
  wire mat_en = mode_i[`CCA_MD_MATCH_EN];
  wire tog_en = mode_i[`CCA_MD_TOGGLE_EN];
  wire pwm_en = mode_i[`CCA_MD_PWM_EN];
  wire wide   = mode_i[`CCA_MD_WIDE_PWM];
  wire m_cap  = ~cmp_en & (mode_i[`CCA_MD_CAP_RISE] | mode_i[`CCA_MD_CAP_FALL]);
  wire m_freq = tog_en & pwm_en;
  wire m_hso  = tog_en & ~pwm_en;
  wire m_p16  = pwm_en & ~tog_en & wide;
  wire m_pwm  = pwm_en & ~tog_en & ~wide;
  wire [10:0] nmask = {cycle_length_select_i == 2'b11, cycle_length_select_i[1], |cycle_length_select_i, 8'hFF};
  wire match16 = tick_i & (count_i == cmp_o);
  wire match_lo = tick_i & (count_i[7:0] == cmp_o[7:0]);
  wire match_n = tick_i & ((count_i[10:0] & nmask) == (cmp_o[10:0] & nmask));
  wire pwm_hit = (cycle_length_select_i == 2'b00) ? match_lo : match_n;
  wire low_ovf = tick_i & (count_i[7:0] == 8'hFF);
  wire ovf16 = tick_i & (count_i == 16'hFFFF);
  wire cap_hit = m_cap & ((mode_i[`CCA_MD_CAP_RISE] & pin_rise_i) |
                          (mode_i[`CCA_MD_CAP_FALL] & pin_fall_i));
  wire cmp_evt = cmp_en & mat_en & match16 & ~pwm_en;
  wire frq_evt = cmp_en & mat_en & match16 & m_freq;
  wire pwm_evt = cmp_en & mat_en & ((m_pwm & pwm_hit) | (m_p16 & match16));
  assign event_o = cap_hit | cmp_evt | frq_evt | pwm_evt;
  // zero half-period means 256 (8-bit wrap gives it free)
  wire [7:0] freq_next = cmp_o[7:0] + cmp_o[15:8];
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmp_o    <= `CCA_CMP_RESET;
      reload_o <= `CCA_CMP_RESET;
      pin_o    <= 1'b0;
    end
    else
    begin
      if (wr_low_i & bank_i)
        reload_o[7:0] <= wdata_i;
      if (wr_high_i & bank_i)
        reload_o[15:8] <= wdata_i;
      if (wr_low_i & ~bank_i)
        cmp_o[7:0] <= wdata_i;
      else if (cap_hit)
        cmp_o[7:0] <= count_i[7:0];
      else if (m_freq & cmp_en & match_lo)
        cmp_o[7:0] <= freq_next;
      else if (m_pwm & (cycle_length_select_i == 2'b00) & low_ovf)
        cmp_o[7:0] <= cmp_o[15:8];
      else if (m_pwm & (cycle_length_select_i != 2'b00) & ovf_n_i)
        cmp_o[7:0] <= reload_o[7:0];
      if (wr_high_i & ~bank_i)
        cmp_o[15:8] <= wdata_i;
      else if (cap_hit)
        cmp_o[15:8] <= count_i[15:8];
      else if (m_pwm & (cycle_length_select_i != 2'b00) & ovf_n_i)
        cmp_o[15:8] <= reload_o[15:8];
      if ((m_pwm | m_p16) & ~cmp_en)
        pin_o <= 1'b0;
      // high on match, low on overflow
      else if (m_pwm & pwm_hit)
        pin_o <= 1'b1;
      else if (m_pwm & ovf_n_i)
        pin_o <= 1'b0;
      else if (m_p16 & match16)
        pin_o <= 1'b1;
      else if (m_p16 & ovf16)
        pin_o <= 1'b0;
      else if (m_hso & cmp_en & mat_en & match16)
        pin_o <= ~pin_o;
      else if (m_freq & cmp_en & match_lo)
        pin_o <= ~pin_o;
    end
  end
endmodule

// ### cca_pin_partner.sv
// partner model: outside drivers on the three module pins
// assumes the bench requests levels on want_i, sampled on core_clk_i
`timescale 1ns/1ps
module cca_pin_partner (
  input  wire       core_clk_i,  // system clock
  input  wire       reset_i,     // async reset, active high
  input  wire [2:0] want_i,      // requested pin levels
  output reg  [2:0] ext_o        // levels driven onto the pins
);
  reg     [1:0] held_r [0:2];
  integer       n;
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      ext_o <= 3'h0;
      for (n = 0; n < 3; n = n + 1)
        held_r[n] <= 2'h0;
    end
    else
      for (n = 0; n < 3; n = n + 1)
        if (want_i[n] != ext_o[n] && held_r[n][1])
        begin
          ext_o[n]  <= want_i[n];
          held_r[n] <= 2'h0;
        end
        else if (held_r[n] != 2'h3)
          held_r[n] <= held_r[n] + 2'h1;
endmodule

// ### cca_array_monitor.sv
// port checks for the counter array
// assumes it is bound into cca_array and sees only its ports
`timescale 1ns/1ps
module cca_array_monitor (
  input wire       core_clk_i,   // system clock
  input wire       reset_i,      // async reset, active high
  input wire       cnt_tick_i,   // counter advance strobe
  input wire       cnt_run_i,    // counter run enable
  input wire [3:0] reg_addr_i,   // register address
  input wire       reg_wr_i,     // write strobe
  input wire       reg_rd_i,     // read strobe
  input wire [7:0] reg_wdata_i,  // write data
  input wire [7:0] reg_rdata_o,  // read data
  input wire [2:0] pin_i,        // pin levels
  input wire [2:0] pin_o,        // pin drive levels
  input wire [2:0] pin_oe_n_o,   // pin enables, low drives
  input wire       irq_o         // interrupt request
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // mode shadows rebuilt from write traffic alone
  reg     [7:0] m_r [0:2];
  reg           ovf_ie_r;
  integer       k;
  wire          adv = cnt_tick_i && cnt_run_i;
  wire    [2:0] oe_exp = ~{m_r[2][6] | m_r[2][1], m_r[1][6] | m_r[1][1], m_r[0][6] | m_r[0][1]};
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      ovf_ie_r <= 1'b0;
      for (k = 0; k < 3; k = k + 1)
        m_r[k] <= 8'h00;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 4'h1)
        ovf_ie_r <= reg_wdata_i[6];
      for (k = 0; k < 3; k = k + 1)
        if (reg_addr_i == 4'h4 + k[3:0])
          m_r[k] <= reg_wdata_i;
        else if (reg_addr_i == 4'h8 + k[3:0])
          m_r[k][6] <= 1'b0;
        else if (reg_addr_i == 4'hC + k[3:0])
          m_r[k][6] <= 1'b1;
    end
  a_mode_readback: assert property (reg_addr_i == 4'h4 |-> reg_rdata_o == m_r[0])
    else $error("mode read differs from written value");
  a_low_clears_en: assert property (reg_addr_i == 4'h4 && $past(reg_wr_i, 2)
    && $past(reg_addr_i, 2) == 4'h8 |-> !reg_rdata_o[6]) else $error("low write kept enable");
  a_high_sets_en: assert property (reg_addr_i == 4'h4 && $past(reg_wr_i, 2)
    && $past(reg_addr_i, 2) == 4'hC |-> reg_rdata_o[6]) else $error("high write left enable");
  a_unmapped_zero: assert property (reg_addr_i inside {4'h7, 4'hB, 4'hF} |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_oe_follows_mode: assert property ($stable(oe_exp) [*2] |-> pin_oe_n_o == oe_exp)
    else $error("pin enable disagrees with mode");
  a_irq_needs_en: assert property (irq_o |-> m_r[0][0] | m_r[1][0] | m_r[2][0] | ovf_ie_r)
    else $error("interrupt without any enable");
  a_pwm_off_low: assert property ((m_r[0][1] && !m_r[0][6] && !m_r[0][2]) [*3] |-> !pin_o[0])
    else $error("pwm output high with comparator off");
  a_pin_hold_idle: assert property ((!adv && !reg_wr_i) [*3] |-> $stable(pin_o))
    else $error("pin changed without counter advance");
endmodule
bind cca_array cca_array_monitor u_mon (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .cnt_tick_i(cnt_tick_i), .cnt_run_i(cnt_run_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));

// ### testbench.sv
// self-checking bench for the counter array capture/compare block
// assumes the design, the pin partner and the monitor are compiled first
`timescale 1ns/1ps
module testbench;
  reg        clk;
  reg        rst;
  reg        tick;
  reg        run;
  reg  [3:0] addr;
  reg        wr;
  reg        rd;
  reg  [7:0] wdata;
  reg  [2:0] want;
  reg  [7:0] d;
  reg  [7:0] d2;
  wire [7:0] rdata;
  wire [2:0] ext;
  wire [2:0] dpin;
  wire [2:0] oe_n;
  wire       irq;
  wire [2:0] pin_lvl = (~oe_n & dpin) | (oe_n & ext);
  integer    failures, num_checks, cycles, seed, cnt, n, i, v;
  cca_array DUT (.core_clk_i(clk), .reset_i(rst), .cnt_tick_i(tick), .cnt_run_i(run),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .pin_i(pin_lvl), .pin_o(dpin), .pin_oe_n_o(oe_n), .irq_o(irq));
  cca_pin_partner u_part (.core_clk_i(clk), .reset_i(rst), .want_i(want), .ext_o(ext));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  end
  endtask
  task wreg(input [3:0] a, input [7:0] b);
  begin
    @(posedge clk);
    addr  <= a;
    wdata <= b;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= 4'hF;
  end
  endtask
  // read data is combinational and is taken at the edge that samples the strobe
  task rreg(input [3:0] a, output [7:0] q);
  begin
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    q = rdata;
    rd   <= 1'b0;
    addr <= 4'hF;
  end
  endtask
  task wcmp(input integer c);
  begin
    wreg(4'h8, c[7:0]);
    wreg(4'hC, c[15:8]);
  end
  endtask
  task set_cnt(input integer c);
  begin
    wreg(4'h2, c[7:0]);
    wreg(4'h3, c[15:8]);
    cnt = c;
  end
  endtask
  task ticks(input integer t);
  begin
    @(posedge clk);
    tick <= 1'b1;
    run  <= 1'b1;
    repeat (t) @(posedge clk);
    tick <= 1'b0;
    run  <= 1'b0;
    cnt = cnt + t;
    repeat (2) @(posedge clk);
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    seed = 32'h32a8;
    cnt = 0;
    rst = 1'b1;
    tick = 1'b0;
    run = 1'b0;
    addr = 4'hF;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    want = 3'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      rreg(i[3:0], d);
      chk(d, 16'h0000, "reset value");
    end
    // rising, falling and any-edge capture on modules 0, 1 and 2
    wreg(4'h4, 8'h21);
    wreg(4'h5, 8'h10);
    wreg(4'h6, 8'h30);
    set_cnt($random(seed));
    for (i = 0; i < 2; i = i + 1)
    begin
      want <= {3{i == 0}};
      repeat (8) @(posedge clk);
      rreg(4'h0, d);
      chk(d[2:0], (i == 0) ? 3'b101 : 3'b110, "capture flags");
      chk(irq, i == 0, "capture irq");
      rreg(4'hA, d2);
      rreg(4'hE, d);
      chk({d, d2}, cnt[15:0], "captured count");
      wreg(4'h0, 8'h00);
      rreg(4'h0, d);
      chk(d, 16'h0000, "flags cleared");
    end
    // frequency output on module 1: step of four, then a zero step of 256
    wreg(4'h5, 8'h4E);
    wreg(4'h9, 8'h10);
    wreg(4'hD, 8'h04);
    set_cnt(16'h040C);
    ticks(8);
    chk(dpin[1], 1'b1, "freq toggle");
    rreg(4'h9, d);
    chk(d, 16'h0014, "freq advance");
    rreg(4'h0, d);
    chk(d[1], 1'b1, "freq flag");
    wreg(4'h0, 8'h00);
    ticks(4);
    chk(dpin[1], 1'b0, "freq second toggle");
    wreg(4'hD, 8'h00);
    ticks(256);
    chk(dpin[1], 1'b1, "freq 256 wait");
    ticks(1);
    chk(dpin[1], 1'b0, "freq 256 end");
    // 16-bit pwm on module 2
    wreg(4'h6, 8'hCA);
    wreg(4'hA, 8'hF8);
    wreg(4'hE, 8'hFF);
    set_cnt(16'hFFF0);
    ticks(12);
    chk(dpin[2], 1'b1, "wide pwm set");
    rreg(4'h0, d);
    chk(d[2], 1'b1, "wide pwm flag");
    ticks(6);
    chk(dpin[2], 1'b0, "wide pwm reset");
    // toggle output, then comparator off on the second pass
    wreg(4'h4, 8'h4D);
    v = 16'h0100 + ($random(seed) & 16'h7FFF);
    wcmp(v[15:0]);
    rreg(4'h4, d);
    chk(d, 16'h004D, "enable set");
    for (i = 0; i < 2; i = i + 1)
    begin
      set_cnt(v - 3);
      ticks(5);
      chk(dpin[0], 1'b1, "toggle level");
      rreg(4'h0, d);
      chk(d[0], i == 0, "match flag");
      wreg(4'h0, 8'h00);
      wreg(4'h8, v[7:0]);
    end
    rreg(4'h4, d);
    chk(d, 16'h000D, "enable cleared");
    // every cycle length: reload bank one below the live compare value
    wreg(4'h4, 8'h4A);
    for (i = 0; i < 4; i = i + 1)
    begin
      n = 1 << (8 + i);
      v = (i == 0) ? 16'hF0F8 : n - 8;
      wreg(4'h1, {2'b11, 4'h0, i[1:0]});
      wcmp(v - 1);
      wreg(4'h1, {2'b01, 4'h0, i[1:0]});
      wcmp(v[15:0]);
      set_cnt(n - 16);
      ticks(12);
      chk(dpin[0], 1'b1, "pwm set");
      rreg(4'h0, d);
      chk(d[0], 1'b1, "pwm flag");
      wreg(4'h0, 8'h00);
      ticks(6);
      chk(dpin[0], 1'b0, "pwm reset");
      rreg(4'h1, d);
      chk(d[5], 1'b1, "cycle overflow");
      chk(irq, 1'b1, "overflow irq");
      rreg(4'h8, d2);
      rreg(4'hC, d);
      chk({d, d2}, (i == 0) ? 16'hF0F0 : v[15:0] - 16'h0001, "reloaded");
    end
    wreg(4'h8, v[7:0]);
    set_cnt(n - 16);
    ticks(12);
    chk(dpin[0], 1'b0, "zero duty");
    tally_and_finish;
  end
endmodule
